// ==== hw/sensor_config_event_control.sv ====
// Purpose: configuration register and event output control of the sensor
// Assumes: serial engine presents one-cycle write strobes with pointer and data
// Notes:   limit registers, converter and comparators live outside this block
`timescale 1ns/100ps

module sensor_config_event_control
(
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,

    // register access from the serial engine
    input  wire sensor_cfg_pkg::reg_req_s reg_req,
    output logic [15:0]                  reg_rdata,

    // comparison results from the limit datapath
    input  wire sensor_cfg_pkg::cmp_s    cmp,

    // controls toward converter and limit registers
    output logic                         low_power_stop,
    output logic [1:0]                   limit_hysteresis,
    output logic [4:0]                   hysteresis_quarters,
    output logic                         critical_limit_lock,
    output logic                         window_limit_lock,

    // event pin, open-drain style when active low
    output logic                         event_out,
    output logic                         event_oe_n,
    output logic                         event_asserted
);
    import sensor_cfg_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    cfg_s       cfg_ff;
    cfg_s       nxt_cfg;
    logic       int_flag_ff;
    logic       nxt_int_flag;
    logic       win_cond_ff;
    logic       nxt_win_cond;
    evt_state_e evt_state_ff;
    evt_state_e nxt_evt_state;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic       out_ff;
    logic       nxt_out;
    logic       oe_n_ff;
    logic       nxt_oe_n;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    logic       cfg_wr;
    logic       locked;
    logic       int_clear;
    logic       win_cond;
    logic       crit_cond;
    logic       win_rise;
    logic       evt_level;

    always_comb
    begin
        cfg_wr    = reg_req.wr && (reg_req.ptr == CFG_PTR);
        locked    = cfg_ff.crit_lock || cfg_ff.win_lock;
        int_clear = cfg_wr && reg_req.wdata[INT_CLEAR_POS];
    end

    // lock values before the write protect that write; a lock set in the
    // same word only guards the following writes
    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (cfg_wr)
        begin
            if (!locked)
            begin
                nxt_cfg.limit_hysteresis =
                    reg_req.wdata[HYST_MSB_POS:HYST_LSB_POS];
            end
            if (!locked || !reg_req.wdata[STOP_POS])
            begin
                nxt_cfg.low_power_stop = reg_req.wdata[STOP_POS];
            end
            // locks are set-only; no write can release them
            nxt_cfg.crit_lock = cfg_ff.crit_lock
                                || reg_req.wdata[CRIT_LOCK_POS];
            nxt_cfg.win_lock  = cfg_ff.win_lock
                                || reg_req.wdata[WIN_LOCK_POS];
            if (!locked)
            begin
                nxt_cfg.evt_enable      = reg_req.wdata[EVT_EN_POS];
                nxt_cfg.evt_active_high = reg_req.wdata[EVT_POL_POS];
                nxt_cfg.evt_int_mode    = reg_req.wdata[EVT_MODE_POS];
            end
            if (!cfg_ff.win_lock)
            begin
                nxt_cfg.evt_crit_only = reg_req.wdata[EVT_SEL_POS];
            end
        end
    end

    // ------------------------------------------------------------------
    // event conditions
    // ------------------------------------------------------------------
    always_comb
    begin
        crit_cond = cmp.ge_critical_limit;
        win_cond  = !cfg_ff.evt_crit_only
                    && (cmp.gt_upper_limit || cmp.lt_lower_limit);
        // comparator level frozen while stopped, so a condition that rose during
        // stop gives an edge on return and latches a new interrupt
        nxt_win_cond = cfg_ff.low_power_stop ? win_cond_ff : win_cond;
        win_rise     = win_cond && !win_cond_ff && !cfg_ff.low_power_stop;
    end

    // interrupt flag: a new crossing in the clear cycle is kept
    always_comb
    begin
        nxt_int_flag = int_flag_ff;
        if (int_clear)
        begin
            nxt_int_flag = 1'b0;
        end
        if (win_rise && cfg_ff.evt_int_mode)
        begin
            nxt_int_flag = 1'b1;
        end
    end

    always_comb
    begin
        if (cfg_ff.evt_int_mode)
        begin
            evt_level = crit_cond || int_flag_ff;
        end
        else
        begin
            evt_level = crit_cond || win_cond;
        end
    end

    // ------------------------------------------------------------------
    // event output state
    // ------------------------------------------------------------------
    always_comb
    begin
        case (evt_state_ff)
            EVT_IDLE:
            begin
                if (cfg_ff.low_power_stop)
                begin
                    nxt_evt_state = EVT_STOPPED;
                end
                else if (cfg_ff.evt_enable && evt_level)
                begin
                    nxt_evt_state = EVT_ACTIVE;
                end
                else
                begin
                    nxt_evt_state = EVT_IDLE;
                end
            end
            EVT_ACTIVE:
            begin
                if (cfg_ff.low_power_stop)
                begin
                    nxt_evt_state = EVT_STOPPED;
                end
                else if (!(cfg_ff.evt_enable && evt_level))
                begin
                    nxt_evt_state = EVT_IDLE;
                end
                else
                begin
                    nxt_evt_state = EVT_ACTIVE;
                end
            end
            EVT_STOPPED:
            begin
                if (cfg_ff.low_power_stop)
                begin
                    nxt_evt_state = EVT_STOPPED;
                end
                else
                begin
                    nxt_evt_state = EVT_IDLE;
                end
            end
            default:
            begin
                nxt_evt_state = EVT_IDLE;
            end
        endcase
    end

    // pin drive: active low only pulls down, active high drives both levels
    always_comb
    begin
        if (nxt_evt_state == EVT_ACTIVE)
        begin
            nxt_out  = nxt_cfg.evt_active_high;
            nxt_oe_n = 1'b0;
        end
        else
        begin
            nxt_out  = 1'b0;
            nxt_oe_n = !nxt_cfg.evt_active_high;
        end
    end

    // ------------------------------------------------------------------
    // readback
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_rdata = RDATA_RST;
        if (reg_req.ptr == CFG_PTR)
        begin
            nxt_rdata[HYST_MSB_POS:HYST_LSB_POS] = cfg_ff.limit_hysteresis;
            nxt_rdata[STOP_POS]      = cfg_ff.low_power_stop;
            nxt_rdata[CRIT_LOCK_POS] = cfg_ff.crit_lock;
            nxt_rdata[WIN_LOCK_POS]  = cfg_ff.win_lock;
            nxt_rdata[INT_CLEAR_POS] = 1'b0;
            nxt_rdata[EVT_STAT_POS]  = (evt_state_ff == EVT_ACTIVE);
            nxt_rdata[EVT_EN_POS]    = cfg_ff.evt_enable;
            nxt_rdata[EVT_SEL_POS]   = cfg_ff.evt_crit_only;
            nxt_rdata[EVT_POL_POS]   = cfg_ff.evt_active_high;
            nxt_rdata[EVT_MODE_POS]  = cfg_ff.evt_int_mode;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cfg_ff.limit_hysteresis <= HYST_RST;
            cfg_ff.low_power_stop   <= BIT_RST;
            cfg_ff.crit_lock        <= BIT_RST;
            cfg_ff.win_lock         <= BIT_RST;
            cfg_ff.evt_enable       <= BIT_RST;
            cfg_ff.evt_crit_only    <= BIT_RST;
            cfg_ff.evt_active_high  <= BIT_RST;
            cfg_ff.evt_int_mode     <= BIT_RST;
            int_flag_ff             <= BIT_RST;
            win_cond_ff             <= BIT_RST;
            evt_state_ff            <= EVT_IDLE;
            rdata_ff                <= RDATA_RST;
            out_ff                  <= 1'b0;
            oe_n_ff                 <= 1'b1;
        end
        else
        begin
            cfg_ff       <= nxt_cfg;
            int_flag_ff  <= nxt_int_flag;
            win_cond_ff  <= nxt_win_cond;
            evt_state_ff <= nxt_evt_state;
            rdata_ff     <= nxt_rdata;
            out_ff       <= nxt_out;
            oe_n_ff      <= nxt_oe_n;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_comb
    begin
        case (cfg_ff.limit_hysteresis)
            HYST_CODE_0_0: hysteresis_quarters = HYST_Q_0_0;
            HYST_CODE_1_5: hysteresis_quarters = HYST_Q_1_5;
            HYST_CODE_3_0: hysteresis_quarters = HYST_Q_3_0;
            HYST_CODE_6_0: hysteresis_quarters = HYST_Q_6_0;
            default:       hysteresis_quarters = HYST_Q_0_0;
        endcase
    end

    assign reg_rdata           = rdata_ff;
    assign low_power_stop      = cfg_ff.low_power_stop;
    assign limit_hysteresis    = cfg_ff.limit_hysteresis;
    assign critical_limit_lock = cfg_ff.crit_lock;
    assign window_limit_lock   = cfg_ff.win_lock;
    assign event_out           = out_ff;
    assign event_oe_n          = oe_n_ff;
    assign event_asserted      = (evt_state_ff == EVT_ACTIVE);

endmodule

// ==== hw/sensor_cfg_pkg.sv ====
// Purpose: shared constants and types for the sensor configuration register
// Assumes: one 16-bit configuration word reached through the serial pointer
// Notes:   field positions, reset values and hysteresis codes are named once here
package sensor_cfg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned PTR_W            = 8;
    localparam logic [7:0]  CFG_PTR          = 8'h01;
    localparam int unsigned DATA_W           = 16;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned HYST_MSB_POS     = 10;
    localparam int unsigned HYST_LSB_POS     = 9;
    localparam int unsigned STOP_POS         = 8;
    localparam int unsigned CRIT_LOCK_POS    = 7;
    localparam int unsigned WIN_LOCK_POS     = 6;
    localparam int unsigned INT_CLEAR_POS    = 5;
    localparam int unsigned EVT_STAT_POS     = 4;
    localparam int unsigned EVT_EN_POS       = 3;
    localparam int unsigned EVT_SEL_POS      = 2;
    localparam int unsigned EVT_POL_POS      = 1;
    localparam int unsigned EVT_MODE_POS     = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  HYST_RST         = 2'h0;
    localparam logic        BIT_RST          = 1'h0;
    localparam logic [15:0] RDATA_RST        = 16'h0000;

    // ------------------------------------------------------------------
    // hysteresis codes, amounts in quarter degrees
    // ------------------------------------------------------------------
    localparam logic [1:0]  HYST_CODE_0_0    = 2'h0;
    localparam logic [1:0]  HYST_CODE_1_5    = 2'h1;
    localparam logic [1:0]  HYST_CODE_3_0    = 2'h2;
    localparam logic [1:0]  HYST_CODE_6_0    = 2'h3;
    localparam logic [4:0]  HYST_Q_0_0       = 5'h00;
    localparam logic [4:0]  HYST_Q_1_5       = 5'h06;
    localparam logic [4:0]  HYST_Q_3_0       = 5'h0C;
    localparam logic [4:0]  HYST_Q_6_0       = 5'h18;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EVT_IDLE    = 2'b00,
        EVT_ACTIVE  = 2'b01,
        EVT_STOPPED = 2'b10
    } evt_state_e;

    // stored configuration fields
    typedef struct packed {
        logic [1:0] limit_hysteresis;
        logic       low_power_stop;
        logic       crit_lock;
        logic       win_lock;
        logic       evt_enable;
        logic       evt_crit_only;
        logic       evt_active_high;
        logic       evt_int_mode;
    } cfg_s;

    // serial engine register access
    typedef struct packed {
        logic             wr;
        logic [7:0]       ptr;
        logic [15:0]      wdata;
    } reg_req_s;

    // comparison results from the limit datapath
    typedef struct packed {
        logic ge_critical_limit;
        logic gt_upper_limit;
        logic lt_lower_limit;
    } cmp_s;

endpackage

// ==== tb/cfg_host_model.sv ====
// Purpose: serial engine stand-in issuing config writes and reads
// Assumes: requests change at the falling edge only
// Notes:   idle pointer parks away from config so stale readback shows
`timescale 1ns/100ps
module cfg_host_model
    import sensor_cfg_pkg::*;
(
    // clock and readback
    input  wire logic                    sys_clk,
    input  wire logic [15:0]             reg_rdata,
    // request toward the block
    output sensor_cfg_pkg::reg_req_s     reg_req
);
    initial reg_req = '{wr: 1'b0, ptr: 8'h00, wdata: 16'h0000};

    // released data shows the inverse so a stale word never looks valid
    task automatic write_cfg(input logic [15:0] d);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b1, ptr: CFG_PTR, wdata: d};
        @(negedge sys_clk);
        reg_req = '{wr: 1'b0, ptr: 8'h00, wdata: ~d};
    endtask

    task automatic read_cfg(output logic [15:0] d);
        @(negedge sys_clk);
        reg_req.ptr = CFG_PTR;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        d = reg_rdata;
        reg_req.ptr = 8'h00;
    endtask
endmodule

// ==== tb/sensor_cfg_checker.sv ====
// Purpose: port-level assertions for the configuration block
// Assumes: one clock, synchronous active-high reset
// Notes:   interrupt flag is internal, so its timing is judged by the bench
`timescale 1ns/100ps
module sensor_cfg_checker
    import sensor_cfg_pkg::*;
(
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst,
    // register access and comparison results
    input wire sensor_cfg_pkg::reg_req_s reg_req,
    input wire logic [15:0]              reg_rdata,
    input wire sensor_cfg_pkg::cmp_s     cmp,
    // controls and pin
    input wire logic                     low_power_stop,
    input wire logic [1:0]               limit_hysteresis,
    input wire logic [4:0]               hysteresis_quarters,
    input wire logic                     critical_limit_lock,
    input wire logic                     window_limit_lock,
    input wire logic                     event_out,
    input wire logic                     event_oe_n,
    input wire logic                     event_asserted
);
    logic cfg_wr;
    logic locked;
    assign cfg_wr = reg_req.wr && (reg_req.ptr == CFG_PTR);
    assign locked = critical_limit_lock || window_limit_lock;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_hyst_decode: assert property (hysteresis_quarters == ((limit_hysteresis == HYST_CODE_6_0) ? 5'h18 : (limit_hysteresis == HYST_CODE_3_0) ? 5'h0C : (limit_hysteresis == HYST_CODE_1_5) ? 5'h06 : 5'h00))
        else $error("hysteresis decode wrong");
    a_hyst_frozen: assert property (cfg_wr && locked |=> $stable(limit_hysteresis))
        else $error("hysteresis changed while locked");
    a_stop_refused: assert property (cfg_wr && locked && reg_req.wdata[8] && !low_power_stop |=> !low_power_stop)
        else $error("stop set while locked");
    a_stop_clear: assert property (cfg_wr && !reg_req.wdata[8] |=> !low_power_stop)
        else $error("stop clear not taken");
    a_crit_sticky: assert property (critical_limit_lock |=> critical_limit_lock)
        else $error("critical lock dropped");
    a_win_sticky: assert property (window_limit_lock |=> window_limit_lock)
        else $error("window lock dropped");
    a_stop_quiet: assert property (low_power_stop [*2] |-> !event_asserted)
        else $error("event active in stop");
    a_drive_asserted: assert property (event_asserted |-> !event_oe_n)
        else $error("asserted event not driven");
    a_rsvd_zero: assert property (reg_rdata[15:11] == 5'h00 && !reg_rdata[5])
        else $error("reserved or clear bit reads one");
    a_other_ptr: assert property ((reg_req.ptr != CFG_PTR) [*3] |-> reg_rdata == 16'h0000)
        else $error("readback without config pointer");
    a_status_mirror: assert property ($past(reg_req.ptr == CFG_PTR)
        |-> reg_rdata[4] == $past(event_asserted))
        else $error("status bit differs from event state");
    a_released_low: assert property (event_oe_n |-> !event_out)
        else $error("released pin shows high value");
endmodule

bind sensor_config_event_control sensor_cfg_checker sensor_cfg_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .cmp(cmp),
    .low_power_stop(low_power_stop), .limit_hysteresis(limit_hysteresis),
    .hysteresis_quarters(hysteresis_quarters), .critical_limit_lock(critical_limit_lock),
    .window_limit_lock(window_limit_lock), .event_out(event_out), .event_oe_n(event_oe_n),
    .event_asserted(event_asserted));

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the configuration block
// Assumes: inputs change at the falling edge
// Notes:   pin checks pack asserted, out and oe_n into three bits
`timescale 1ns/100ps
module tb_top;
    import sensor_cfg_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    reg_req_s    reg_req;
    cmp_s        cmp = '0;
    logic [15:0] reg_rdata;
    logic        low_power_stop;
    logic [1:0]  limit_hysteresis;
    logic [4:0]  hysteresis_quarters;
    logic        critical_limit_lock;
    logic        window_limit_lock;
    logic        event_out;
    logic        event_oe_n;
    logic        event_asserted;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #10 sys_clk = ~sys_clk;

    sensor_config_event_control sensor_config_event_control_inst (
        .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .cmp(cmp),
        .low_power_stop(low_power_stop), .limit_hysteresis(limit_hysteresis),
        .hysteresis_quarters(hysteresis_quarters), .critical_limit_lock(critical_limit_lock),
        .window_limit_lock(window_limit_lock), .event_out(event_out),
        .event_oe_n(event_oe_n), .event_asserted(event_asserted));
    cfg_host_model cfg_host_model_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_req(reg_req));

    // ------------------------------------------------------------------
    // shared checks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cfg(input logic [15:0] exp);
        logic [15:0] d;
        cfg_host_model_inst.read_cfg(d);
        chk(d, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic chk_pin(input logic [2:0] exp);
        settle();
        chk({13'h0000, event_asserted, event_out, event_oe_n}, {13'h0000, exp});
    endtask
    task automatic set_cmp(input logic [2:0] c);
        @(negedge sys_clk);
        cmp = c;
    endtask
    task automatic wr(input logic [15:0] d);
        cfg_host_model_inst.write_cfg(d);
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        do_reset();
        chk_cfg(16'h0000);
        chk_pin(3'b001);
        chk({14'h0000, critical_limit_lock, window_limit_lock}, 16'h0000);
    endtask
    task automatic t_hyst();
        logic [4:0] q [4] = '{5'h00, 5'h06, 5'h0C, 5'h18};
        for (int i = 0; i < 4; i++)
        begin
            wr(16'(i) << 9);
            chk_cfg(16'(i) << 9);
            chk({11'h000, hysteresis_quarters}, {11'h000, q[i]});
        end
        wr(16'h0000);
    endtask
    task automatic t_comparator();
        wr(16'h0008);
        set_cmp(3'b010);
        chk_pin(3'b100);
        chk_cfg(16'h0018);
        set_cmp(3'b000);
        chk_pin(3'b001);
        wr(16'h0000);
        set_cmp(3'b001);
        chk_pin(3'b001);
        wr(16'h000A);
        chk_pin(3'b110);
        wr(16'h000E);
        chk_pin(3'b000);
        set_cmp(3'b100);
        chk_pin(3'b110);
        set_cmp(3'b000);
        wr(16'h0000);
    endtask
    task automatic t_interrupt();
        wr(16'h0009);
        set_cmp(3'b010);
        chk_pin(3'b100);
        set_cmp(3'b000);
        chk_pin(3'b100);
        chk_cfg(16'h0019);
        wr(16'h0009);
        chk_pin(3'b100);
        wr(16'h0029);
        chk_pin(3'b001);
        chk_cfg(16'h0009);
        set_cmp(3'b010);
        chk_pin(3'b100);
        wr(16'h0109);
        chk_pin(3'b001);
        chk_cfg(16'h0109);
        chk({15'h0000, low_power_stop}, 16'h0001);
        wr(16'h0129);
        set_cmp(3'b000);
        wr(16'h0009);
        chk_pin(3'b001);
        wr(16'h0108);
        set_cmp(3'b010);
        chk_pin(3'b001);
        wr(16'h0008);
        chk_pin(3'b100);
        set_cmp(3'b000);
    endtask
    task automatic t_locks();
        do_reset();
        wr(16'h0100);
        wr(16'h0740);
        chk_cfg(16'h0740);
        wr(16'h03BF);
        chk_cfg(16'h07C0);
        wr(16'h0000);
        chk_cfg(16'h06C0);
        chk({14'h0000, critical_limit_lock, window_limit_lock}, 16'h0003);
        do_reset();
        chk_cfg(16'h0000);
        wr(16'h0080);
        wr(16'h010F);
        chk_cfg(16'h0084);
    endtask

    // bound sized well above the full sequence length
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    initial
    begin
        t_reset();
        t_hyst();
        t_comparator();
        t_interrupt();
        t_locks();
        finish_test();
    end
endmodule
